// [common/crs_pkg.sv]
// Package for the core register, stack and bank select block.
// Assumes a single core clock and a data space of 256 byte locations.
package crs_pkg;
  localparam logic [7:0] ADDR_PTR_FIRST   = 8'h80;
  localparam logic [7:0] ADDR_PTR_SECOND  = 8'h81;
  localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
  localparam logic [7:0] ADDR_BANK_SEL    = 8'hCB;
  localparam logic [7:0] ADDR_SUM_RESULT  = 8'hFF;
  localparam logic [7:0] BANK_LIMIT       = 8'h3F;
  localparam int         BANK_ONE_POS     = 3;
  localparam int         BANK_TWO_POS     = 4;
  localparam logic [7:0] BANK_NONE        = 8'h00;
  localparam logic [7:0] BANK_PAGE_ONE    = 8'h08;
  localparam logic [7:0] BANK_PAGE_TWO    = 8'h10;
  localparam int         PC_WIDTH         = 12;
  localparam int         STACK_DEPTH      = 6;
  localparam logic [11:0] RESET_VECTOR    = 12'hFFE;
  typedef enum logic [1:0] {
    CTX_NORMAL = 2'b00,
    CTX_INT    = 2'b01,
    CTX_NMI    = 2'b10
  } crs_ctx_t;
  typedef enum logic [2:0] {
    PCOP_NEXT   = 3'b000,
    PCOP_JUMP   = 3'b001,
    PCOP_CALL   = 3'b010,
    PCOP_BRANCH = 3'b011,
    PCOP_INT    = 3'b100,
    PCOP_NMI    = 3'b101,
    PCOP_SUBEXIT = 3'b110,
    PCOP_INTEXIT = 3'b111
  } crs_pcop_t;
  typedef enum logic [1:0] {
    FLOP_NONE  = 2'b00,
    FLOP_ARITH = 2'b01,
    FLOP_LOGIC = 2'b10,
    FLOP_CARRY = 2'b11
  } crs_flop_t;
endpackage

// [core/crs_core_regs.sv]
// Core registers, flag pairs, program counter, return stack, bank select.
// Assumes the instruction sequencer drives one step per enabled cycle.
//
// Function
// RQ1: Bank select bit 4 maps page 2, bit 3 maps page 1.
// RQ2: Value 00h selects none, 08h page 1, 10h page 2, others reserved.
// RQ3: Data addresses 00h to 3Fh reach that offset inside the chosen page.
// RQ4: Bank select sits at CBh, write only, full byte writes only.
// RQ5: Reset leaves bank select unchanged; software writes it first.
// RQ6: Interrupt or subroutine entry leaves bank select untouched.
// RQ7: Software sets at most one bank bit at a time.
// RQ8: Interrupt code writes a RAM image before writing bank select.
// RQ9: Accumulator serves the ALU and reads and writes at FFh.
// RQ10: Pointer registers sit at 80h and 81h as ordinary locations.
// RQ11: Short direct registers sit at 82h and 83h as ordinary locations.
// RQ12: Program counter is 12 bits wide, reaching 4096 bytes.
// RQ13: PC loads jump, call, branch, vector, pops on returns, else increments.
// RQ14: Three carry and zero pairs; entry switches to the matching pair.
// RQ15: Interrupt exit restores the pair active before the entry.
// RQ16: Context switches keep every pair's values intact.
// RQ17: Carry takes arithmetic carry, tested bit, or rotate-left output.
// RQ18: Zero is set when the latest result is zero.
// RQ19: After reset the core runs in the NMI context.
// RQ20: Six 12-bit stack levels shift deeper on call or interrupt.
// RQ21: A return moves level one to the PC and shifts levels up.
// RQ22: Overflow loses the oldest entry; empty return leaves stack as is.
// RQ23: A read of the bank select address changes nothing.
`timescale 1ns/1ps
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int PAGES = 2
)(
  // Clock and reset.
  input  wire logic                CLK_IN,
  input  wire logic                RST_IN,
  // Data space access.
  input  wire logic                DATA_WR_IN,
  input  wire logic                DATA_RD_IN,
  input  wire logic [7:0]          DATA_ADDR_IN,
  input  wire logic [7:0]          DATA_WDATA_IN,
  output logic      [7:0]          DATA_RDATA_OUT,
  output logic                     DATA_HIT_OUT,
  output logic      [7:0]          BANK_ADDR_OUT,
  output logic      [PAGES-1:0]    BANK_PAGE_OUT,
  // Sequencer controls.
  input  wire logic                STEP_IN,
  input  wire logic [2:0]          PC_OP_IN,
  input  wire logic [11:0]         PC_TARGET_IN,
  input  wire logic [7:0]          BRANCH_OFS_IN,
  input  wire logic [11:0]         INT_VECTOR_IN,
  // Accumulator and flags.
  input  wire logic [1:0]          FLAG_OP_IN,
  input  wire logic                ACC_LOAD_IN,
  input  wire logic [7:0]          ACC_RESULT_IN,
  input  wire logic                ALU_CARRY_IN,
  // Core state.
  output logic      [11:0]         PC_OUT,
  output logic      [7:0]          ACC_OUT,
  output logic                     CARRY_OUT,
  output logic                     ZERO_OUT,
  output logic      [1:0]          CTX_OUT,
  output logic      [2:0]          STACK_LEVEL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State record.
  typedef struct packed {
    logic [7:0]                   ram_bank_select;
    logic [7:0]                   pointer_reg_first;
    logic [7:0]                   pointer_reg_second;
    logic [7:0]                   short_direct_first;
    logic [7:0]                   short_direct_second;
    logic [7:0]                   sum_result_reg;
    logic [11:0]                  program_counter;
    logic [STACK_DEPTH-1:0][11:0] stack;
    logic [2:0]                   level;
    logic [2:0]                   carry;
    logic [2:0]                   zero;
    crs_ctx_t                     ctx;
    crs_ctx_t                     ctx_saved;
    logic [7:0]                   rdata;
    logic                         hit;
  } crs_state_t;

  crs_state_t st;
  crs_state_t next_st;
  logic [7:0] result_zero_src;
  logic [1:0] ci;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    next_st = st;
    ci = st.ctx;
    result_zero_src = ACC_RESULT_IN;
    next_st.hit = 1'b0;
    next_st.rdata = 8'h00;
    if (DATA_RD_IN)
    begin
      if (DATA_ADDR_IN == ADDR_PTR_FIRST)
      begin
        next_st.rdata = st.pointer_reg_first; // see RQ10
        next_st.hit = 1'b1;
      end
      else if (DATA_ADDR_IN == ADDR_PTR_SECOND)
      begin
        next_st.rdata = st.pointer_reg_second; // see RQ10
        next_st.hit = 1'b1;
      end
      else if (DATA_ADDR_IN == ADDR_SHORT_FIRST)
      begin
        next_st.rdata = st.short_direct_first; // see RQ11
        next_st.hit = 1'b1;
      end
      else if (DATA_ADDR_IN == ADDR_SHORT_SECOND)
      begin
        next_st.rdata = st.short_direct_second; // see RQ11
        next_st.hit = 1'b1;
      end
      else if (DATA_ADDR_IN == ADDR_SUM_RESULT)
      begin
        next_st.rdata = st.sum_result_reg; // see RQ9
        next_st.hit = 1'b1;
      end
    end
    if (DATA_WR_IN)
    begin
      if (DATA_ADDR_IN == ADDR_PTR_FIRST)
        next_st.pointer_reg_first = DATA_WDATA_IN; // see RQ10
      else if (DATA_ADDR_IN == ADDR_PTR_SECOND)
        next_st.pointer_reg_second = DATA_WDATA_IN; // see RQ10
      else if (DATA_ADDR_IN == ADDR_SHORT_FIRST)
        next_st.short_direct_first = DATA_WDATA_IN; // see RQ11
      else if (DATA_ADDR_IN == ADDR_SHORT_SECOND)
        next_st.short_direct_second = DATA_WDATA_IN; // see RQ11
      else if (DATA_ADDR_IN == ADDR_BANK_SEL)
        next_st.ram_bank_select = DATA_WDATA_IN; // see RQ4
      else if (DATA_ADDR_IN == ADDR_SUM_RESULT)
        next_st.sum_result_reg = DATA_WDATA_IN; // see RQ9
    end
    if (ACC_LOAD_IN)
      next_st.sum_result_reg = ACC_RESULT_IN; // see RQ9
    case (FLAG_OP_IN)
      FLOP_ARITH:
      begin
        next_st.carry[ci] = ALU_CARRY_IN; // see RQ17
        next_st.zero[ci] = (result_zero_src == 8'h00); // see RQ18
      end
      FLOP_LOGIC:
        next_st.zero[ci] = (result_zero_src == 8'h00); // see RQ18
      FLOP_CARRY:
        next_st.carry[ci] = ALU_CARRY_IN; // see RQ17
      default:
        next_st.zero[ci] = st.zero[ci];
    endcase
    if (STEP_IN)
    begin
      case (PC_OP_IN)
        PCOP_JUMP:
          next_st.program_counter = PC_TARGET_IN; // see RQ13
        PCOP_CALL, PCOP_INT, PCOP_NMI: // see RQ6
        begin
          next_st.stack = {st.stack[STACK_DEPTH-2:0],
                           st.program_counter}; // see RQ20
          if (st.level != 3'(STACK_DEPTH))
            next_st.level = st.level + 3'h1; // see RQ22
          if (PC_OP_IN == PCOP_CALL)
            next_st.program_counter = PC_TARGET_IN; // see RQ13
          else
          begin
            next_st.program_counter = INT_VECTOR_IN; // see RQ13
            next_st.ctx_saved = st.ctx; // see RQ15
            next_st.ctx = (PC_OP_IN == PCOP_NMI) ? CTX_NMI : CTX_INT; // see RQ14
          end
        end
        PCOP_BRANCH:
          next_st.program_counter = st.program_counter +
            {{4{BRANCH_OFS_IN[7]}}, BRANCH_OFS_IN}; // see RQ13
        PCOP_SUBEXIT, PCOP_INTEXIT:
        begin
          if (st.level != 3'h0)
          begin
            next_st.program_counter = st.stack[0]; // see RQ21
            next_st.stack = {12'h000, st.stack[STACK_DEPTH-1:1]};
            next_st.level = st.level - 3'h1;
          end
          else
            next_st.program_counter = st.program_counter + 12'h001; // see RQ22
          if (PC_OP_IN == PCOP_INTEXIT)
            next_st.ctx = st.ctx_saved; // see RQ15
        end
        default:
          next_st.program_counter = st.program_counter + 12'h001; // see RQ13
      endcase
    end
    if (RST_IN)
    begin
      // Bank select, data registers and flags keep their contents.
      next_st.program_counter = RESET_VECTOR; // see RQ13
      next_st.level = 3'h0;
      next_st.ctx = CTX_NMI; // see RQ19
      next_st.ctx_saved = CTX_NORMAL;
      next_st.hit = 1'b0;
      next_st.rdata = 8'h00;
      next_st.ram_bank_select = st.ram_bank_select; // see RQ5
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank window, registered.
  logic [7:0]       bank_addr;
  logic [PAGES-1:0] bank_page;

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      bank_addr <= 8'h00;
      bank_page <= '0;
    end
    else
    begin
      bank_addr <= DATA_ADDR_IN & BANK_LIMIT; // see RQ3
      bank_page <= '0;
      if (DATA_ADDR_IN <= BANK_LIMIT && (DATA_RD_IN || DATA_WR_IN))
      begin
        bank_page[0] <= st.ram_bank_select[BANK_ONE_POS]; // see RQ1
        bank_page[1] <= st.ram_bank_select[BANK_TWO_POS]; // see RQ2
      end
    end
  end

  assign BANK_ADDR_OUT   = bank_addr;
  assign BANK_PAGE_OUT   = bank_page;
  assign DATA_RDATA_OUT  = st.rdata; // see RQ23
  assign DATA_HIT_OUT    = st.hit;
  assign PC_OUT          = st.program_counter; // see RQ12
  assign ACC_OUT         = st.sum_result_reg;
  assign CARRY_OUT       = st.carry[st.ctx]; // see RQ14
  assign ZERO_OUT        = st.zero[st.ctx]; // see RQ16
  assign CTX_OUT         = st.ctx;
  assign STACK_LEVEL_OUT = st.level;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence call_step_s;
    STEP_IN && PC_OP_IN == PCOP_CALL;
  endsequence

  bank_page_map_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (DATA_WR_IN && DATA_ADDR_IN <= BANK_LIMIT) |=>
      BANK_PAGE_OUT == {$past(st.ram_bank_select[BANK_TWO_POS]),
                        $past(st.ram_bank_select[BANK_ONE_POS])}) // see RQ1
    else $error("Bank page does not follow bank select.");
  bank_offset_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    DATA_RD_IN |=> BANK_ADDR_OUT == ($past(DATA_ADDR_IN) & 8'h3F)) // see RQ3
    else $error("Bank offset wrong.");
  bank_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (DATA_WR_IN && DATA_ADDR_IN == ADDR_BANK_SEL) |=>
      st.ram_bank_select == $past(DATA_WDATA_IN)) // see RQ4
    else $error("Bank select not written.");
  bank_keep_a: assert property (@(posedge CLK_IN)
    !(DATA_WR_IN && DATA_ADDR_IN == ADDR_BANK_SEL) |=>
      $stable(st.ram_bank_select)) // see RQ6
    else $error("Bank select changed without a write.");
  acc_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (DATA_RD_IN && DATA_ADDR_IN == ADDR_SUM_RESULT) |=>
      DATA_HIT_OUT && DATA_RDATA_OUT == $past(ACC_OUT)) // see RQ9
    else $error("Accumulator read wrong.");
  pc_next_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (STEP_IN && PC_OP_IN == PCOP_NEXT) |=>
      PC_OUT == $past(PC_OUT) + 12'h001) // see RQ13
    else $error("PC did not increment.");
  call_push_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    call_step_s |=> st.stack[0] == $past(PC_OUT) &&
      PC_OUT == $past(PC_TARGET_IN)) // see RQ20
    else $error("Call did not push the PC.");
  ctx_restore_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (STEP_IN && PC_OP_IN == PCOP_INTEXIT) |=>
      CTX_OUT == $past(st.ctx_saved)) // see RQ15
    else $error("Context not restored.");
  reset_ctx_a: assert property (@(posedge CLK_IN)
    RST_IN |=> CTX_OUT == CTX_NMI) // see RQ19
    else $error("Reset context is not NMI.");

  sequence return_step_s;
    STEP_IN && (PC_OP_IN == PCOP_SUBEXIT || PC_OP_IN == PCOP_INTEXIT);
  endsequence

  return_pop_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    return_step_s ##0 (STACK_LEVEL_OUT != 3'h0) |=>
      PC_OUT == $past(st.stack[0]) &&
      STACK_LEVEL_OUT == $past(STACK_LEVEL_OUT) - 3'h1) // see RQ21
    else $error("Return did not pop the stack.");
  stack_full_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    call_step_s ##0 (STACK_LEVEL_OUT == 3'(STACK_DEPTH)) |=>
      STACK_LEVEL_OUT == 3'(STACK_DEPTH)) // see RQ22
    else $error("Full stack level moved.");
  int_entry_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (STEP_IN && PC_OP_IN == PCOP_INT) |=>
      CTX_OUT == CTX_INT && PC_OUT == $past(INT_VECTOR_IN)) // see RQ14
    else $error("Interrupt entry wrong.");
  bank_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (DATA_RD_IN && DATA_ADDR_IN == ADDR_BANK_SEL) |=>
      !DATA_HIT_OUT && DATA_RDATA_OUT == 8'h00) // see RQ23
    else $error("Bank select read returned data.");

endmodule // crs_core_regs

// [tb/testbench.sv]
// Self-checking bench for the core register, stack and bank select block.
// Assumes the design package and the design module are compiled first.
`timescale 1ns/1ps
module testbench;
  import crs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, step = 1'b0, ld = 1'b0, cy = 1'b0;
  logic [7:0]  addr = 8'h00, wd = 8'h00, ofs = 8'h00, res = 8'h00;
  logic [2:0]  pop = 3'h0;
  logic [1:0]  fop = 2'h0;
  logic [11:0] tgt = 12'h000;
  logic [7:0]  rdata, bank_addr, acc;
  logic [1:0]  page, ctx;
  logic        hit, carry, zero;
  logic [11:0] pc;
  logic [2:0]  level;
  logic [11:0] stk[$];
  logic [7:0]  ra[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  logic [7:0]  bv[4] = '{BANK_PAGE_ONE, BANK_PAGE_TWO, BANK_NONE, 8'h08};
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 7;
  int mpc = 'hFFE, mctx = 2, msave = 0;
  int mc[3], mz[3];
  //////////////////////////////////////////////////////////////
  crs_core_regs #(.PAGES(2)) u_dut (
    .CLK_IN(clk), .RST_IN(rst), .DATA_WR_IN(wr), .DATA_RD_IN(rd),
    .DATA_ADDR_IN(addr), .DATA_WDATA_IN(wd), .DATA_RDATA_OUT(rdata),
    .DATA_HIT_OUT(hit), .BANK_ADDR_OUT(bank_addr), .BANK_PAGE_OUT(page),
    .STEP_IN(step), .PC_OP_IN(pop), .PC_TARGET_IN(tgt),
    .BRANCH_OFS_IN(ofs), .INT_VECTOR_IN(tgt), .FLAG_OP_IN(fop),
    .ACC_LOAD_IN(ld), .ACC_RESULT_IN(res), .ALU_CARRY_IN(cy),
    .PC_OUT(pc), .ACC_OUT(acc), .CARRY_OUT(carry), .ZERO_OUT(zero),
    .CTX_OUT(ctx), .STACK_LEVEL_OUT(level));
  always #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      report_and_stop;
    end
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic pcstep(input logic [2:0] op, input logic [11:0] t,
                        input logic [7:0] o);
    @(posedge clk);
    step <= 1'b1;
    pop <= op;
    tgt <= t;
    ofs <= o;
    @(posedge clk);
    step <= 1'b0;
    #1;
    case (op)
      3'h0: mpc = mpc + 1;
      3'h1: mpc = t;
      3'h3: mpc = mpc + $signed(o);
      3'h6, 3'h7:
      begin
        if (stk.size() > 0) mpc = stk.pop_front();
        else mpc = mpc + 1;
        if (op == 3'h7) mctx = msave;
      end
      default:
      begin
        stk.push_front(12'(mpc));
        if (stk.size() > 6) void'(stk.pop_back());
        mpc = t;
        if (op > 3'h2)
        begin
          msave = mctx;
          mctx = op - 3'h3;
        end
      end
    endcase
    mpc = mpc & 'hFFF;
    check(pc, 12'(mpc));
    check(12'(level), 12'(stk.size()));
    check(12'(ctx), 12'(mctx));
  endtask
  task automatic flag(input logic [1:0] f, input logic [7:0] r,
                      input logic c);
    @(posedge clk);
    fop <= f;
    res <= r;
    cy <= c;
    ld <= 1'b1;
    @(posedge clk);
    fop <= 2'h0;
    ld <= 1'b0;
    #1;
    if (f[0]) mc[mctx] = c;
    if (f == 2'h1 || f == 2'h2) mz[mctx] = (r == 8'h00);
    check(12'(acc), 12'(r));
    check(12'(carry), 12'(mc[mctx]));
    check(12'(zero), 12'(mz[mctx]));
  endtask
  //////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d, a;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(pc, RESET_VECTOR);
    check(12'(ctx), 12'(CTX_NMI));
    foreach (ra[i])
    begin
      d = 8'($random(seed));
      access(1'b1, ra[i], d);
      access(1'b0, ra[i], 8'h00);
      check(12'(rdata), 12'(d));
      check(12'(hit), 12'h001);
    end
    check(12'(acc), 12'(d));
    access(1'b0, ADDR_BANK_SEL, 8'h00);
    check(12'({hit, rdata}), 12'h000);
    $display("Test data space registers done");
    foreach (bv[i])
    begin
      a = 8'($random(seed)) & BANK_LIMIT;
      access(1'b1, ADDR_BANK_SEL, bv[i]);
      access(1'b0, ADDR_BANK_SEL, 8'h00);
      access(1'b0, a, 8'h00);
      check(12'(page), 12'(bv[i][4:3]));
      check(12'(bank_addr), 12'(a));
    end
    $display("Test bank select done");
    pcstep(3'h0, 12'h000, 8'h00);
    pcstep(3'h1, 12'h7F0, 8'h00);
    pcstep(3'h3, 12'h000, 8'hF0);
    pcstep(3'h3, 12'h000, 8'h7F);
    repeat (7) pcstep(3'h2, 12'($random(seed)), 8'h00);
    repeat (7) pcstep(3'h6, 12'h000, 8'h00);
    access(1'b1, BANK_LIMIT, 8'h5A);
    check(12'(page), 12'h001);
    check(12'(bank_addr), 12'(BANK_LIMIT));
    $display("Test program counter and stack done");
    pcstep(3'h7, 12'h000, 8'h00);
    flag(2'h1, 8'h00, 1'b1);
    pcstep(3'h4, 12'h3F0, 8'h00);
    access(1'b1, ADDR_SHORT_FIRST, BANK_PAGE_TWO);
    access(1'b1, ADDR_BANK_SEL, BANK_PAGE_TWO);
    flag(2'h1, 8'h05, 1'b0);
    flag(2'h2, 8'h00, 1'b1);
    flag(2'h3, 8'h07, 1'b1);
    pcstep(3'h7, 12'h000, 8'h00);
    check(12'(carry), 12'(mc[0]));
    check(12'(zero), 12'(mz[0]));
    access(1'b1, 8'h10, 8'h00);
    check(12'(page), 12'h002);
    pcstep(3'h5, 12'h3F8, 8'h00);
    flag(2'h1, 8'h80, 1'b0);
    pcstep(3'h7, 12'h000, 8'h00);
    check(12'(carry), 12'(mc[0]));
    check(12'(zero), 12'(mz[0]));
    $display("Test flag contexts done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    mpc = 'hFFE;
    mctx = 2;
    msave = 0;
    stk.delete();
    check(pc, RESET_VECTOR);
    check(12'(ctx), 12'(CTX_NMI));
    check(12'(level), 12'h000);
    check(12'(carry), 12'(mc[2]));
    check(12'(zero), 12'(mz[2]));
    access(1'b1, BANK_LIMIT, 8'h00);
    check(12'(page), 12'h002);
    pcstep(3'h7, 12'h000, 8'h00);
    check(12'(carry), 12'(mc[0]));
    check(12'(zero), 12'(mz[0]));
    $display("Test reset in mid-run done");
    report_and_stop;
  end
endmodule // testbench
